// >>> hdl/ossc_pkg.sv
// Purpose: constants shared by the serial switch control design
// Assumes: 16-bit frames, eight outputs
// Notes: What this block does is listed below
//
// What this block does
// - command zero turns output off, one on
// - faulted output returns one, normal zero
// - chain data through shifter, status each clock
// - apply command only on chip select rise
// - 16-bit words both ways, MSB first
// - bits 0..7 switch outputs one..eight
// - bits 8..15 enable open-load currents
// - status bits 15..8 always zero
// - status bit n-1 is output n fault
// - status shows previously applied state
// - overtemperature sets status bit
// - short to supply/overcurrent sets status bit
// - open load while on not flagged
// - off open load flagged only when enabled
// - overvoltage forces all off, then restores
// - overtemperature shuts only that output
// - sleep clears command to all off
// - sample on falling, shift on rising edge
// - chip select high ignores clock, output off
// - direct drives OR into outputs five, six
// - apply only 16 plus multiple-of-8 pulses
package ossc_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam int CMD_W = 16;
    localparam int N_OUT = 8;
    localparam int ON_LSB = 0;
    localparam int OLD_LSB = 8;
    localparam int DD5_BIT = 4;
    localparam int DD6_BIT = 5;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [7:0] STATUS_PAD = 8'h00;
    localparam logic [7:0] FAULT_RESET = 8'h00;
    // ****************************************
    // pulse counter values
    // ****************************************
    localparam logic [4:0] CNT_IDLE = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_ZEROS = 5'h07;
    localparam logic [4:0] CNT_FIRST = 5'h10;
    localparam logic [4:0] CNT_WRAP = 5'h17;
    // ****************************************
    // synchroniser bundle
    // ****************************************
    // cs_n, tag, enable, two drives, overvoltage, three fault bytes
    localparam int SYNC_W = 30;
    // chip select resets high so release makes no false rise
    localparam logic [29:0] SYNC_RST = 30'h2000_0000;
endpackage

// >>> hdl/ossc_sync.sv
// Purpose: two-flop synchroniser for a bundle of level inputs
// Assumes: every bit is an independent slow level
// Notes: reset values per bit, first stage read only by second
`timescale 1ns/100ps
module ossc_sync
    import ossc_pkg::*;
#(
    parameter int W = SYNC_W,
    parameter logic [W-1:0] RST = '0
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb
    begin
        next_meta = resetn ? async_in : RST;
        next_sync = resetn ? meta : RST;
    end

    always_ff @(posedge mclk)
    begin
        meta <= next_meta;
        sync_out <= next_sync;
    end
endmodule // ossc_sync

// >>> hdl/ossc_chan.sv
// Purpose: per-output drive gating and fault flag
// Assumes: all inputs already on mclk
// Notes: purely combinational, the top registers the results
`timescale 1ns/100ps
module ossc_chan
(
    // command
    input wire logic on_cmd,
    input wire logic det_en,
    // conditions
    input wire logic thermal,
    input wire logic overcurrent,
    input wire logic open_load,
    input wire logic overvolt,
    // results
    output logic drive,
    output logic fault
);
    always_comb
    begin
        // gating leaves the command intact, so recovery restores it
        drive = on_cmd & ~thermal & ~overvolt;
        fault = thermal
            | overcurrent
            | (open_load & ~on_cmd & det_en);
    end
endmodule // ossc_chan

// >>> hdl/ossc_ctrl.sv
// Purpose: serial control and fault reporting of an eight-output switch
// Assumes: mclk much faster than sclk; sclk low at chip select edges
// Notes: link shifter runs on sclk, command and faults on mclk
`timescale 1ns/100ps
module ossc_ctrl
    import ossc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_command_in,
    output logic serial_status_out,
    output logic serial_status_oe,
    // control pins
    input wire logic enable,
    input wire logic direct_drive_five,
    input wire logic direct_drive_six,
    input wire logic battery_supply_overvoltage,
    // per-output conditions
    input wire logic [7:0] thermal_limit_fault,
    input wire logic [7:0] overcurrent_fault,
    input wire logic [7:0] open_load_sense,
    // drivers
    output logic [7:0] output_drive,
    output logic [7:0] open_load_current_en
);
    // ****************************************
    // link domain: shift register on sclk
    // ****************************************
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic tag;
    logic next_tag;
    logic started;
    logic end_tag;
    logic do_q;
    logic next_do;
    logic [15:0] status_word;
    logic [7:0] status_hold;

    // status_hold only moves while chip select is high, so the link
    // sees a still word during the frame
    assign status_word = {STATUS_PAD, status_hold};

    always_comb
    begin
        next_sr = sr;
        next_cnt = cnt;
        next_tag = tag;
        if (!cs_n)
        begin
            if (!started)
            begin
                // first edge loads the status word and shifts in one bit
                next_sr = {status_word[14:0], serial_command_in};
                next_cnt = CNT_ONE;
                next_tag = ~tag;
            end
            else
            begin
                next_sr = {sr[14:0], serial_command_in};
                next_cnt = (cnt == CNT_WRAP) ? CNT_FIRST : cnt + CNT_ONE;
            end
        end
    end

    // link regs reset while sclk is idle, so release timing is harmless
    always_ff @(negedge sclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sr <= CMD_RESET;
            cnt <= CNT_IDLE;
            tag <= 1'b0;
        end
        else
        begin
            sr <= next_sr;
            cnt <= next_cnt;
            tag <= next_tag;
        end
    end

    // frame marker: the first fall toggles tag, chip select rise
    // copies it back, so no sclk edge is needed to end a frame
    always_ff @(posedge cs_n or negedge resetn)
    begin
        if (!resetn)
        begin
            end_tag <= 1'b0;
        end
        else
        begin
            end_tag <= tag;
        end
    end

    assign started = tag ^ end_tag;

    always_comb
    begin
        next_do = cs_n ? do_q : sr[15];
    end

    always_ff @(posedge sclk or negedge resetn)
    begin
        if (!resetn)
        begin
            do_q <= 1'b0;
        end
        else
        begin
            do_q <= next_do;
        end
    end

    // before the first falling edge the status MSB is zero anyway
    assign serial_status_out = do_q & started;
    assign serial_status_oe = ~cs_n;

    // ****************************************
    // synchronisers into mclk
    // ****************************************
    logic [SYNC_W-1:0] sync_q;
    logic cs_s;
    logic tag_s;
    logic en_s;
    logic dd5_s;
    logic dd6_s;
    logic ov_s;
    logic [7:0] th_s;
    logic [7:0] oc_s;
    logic [7:0] ol_s;

    ossc_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync
    (
        .mclk(mclk),
        .resetn(resetn),
        .async_in({cs_n, tag, enable, direct_drive_five, direct_drive_six,
            battery_supply_overvoltage, thermal_limit_fault, overcurrent_fault,
            open_load_sense}),
        .sync_out(sync_q)
    );

    assign {cs_s, tag_s, en_s, dd5_s, dd6_s, ov_s, th_s, oc_s, ol_s} = sync_q;

    // ****************************************
    // command register and apply
    // ****************************************
    logic cs_d;
    logic seen_tag;
    logic [15:0] cmd;
    logic [15:0] next_cmd;
    logic next_seen;
    logic cs_rise;
    logic frame_ok;
    logic [7:0] eff_on;
    logic [7:0] drive_v;
    logic [7:0] fault_v;
    logic [7:0] next_hold;

    assign cs_rise = cs_s & ~cs_d;
    // cnt and sr are still since the last sclk edge when this is read
    assign frame_ok = (tag_s != seen_tag) && (cnt == CNT_FIRST);

    always_comb
    begin
        next_cmd = cmd;
        next_seen = seen_tag;
        if (cs_rise)
        begin
            next_seen = tag_s;
            if (frame_ok)
            begin
                next_cmd = sr;
            end
        end
        if (!en_s)
        begin
            next_cmd = CMD_RESET;
        end
        next_hold = cs_s ? fault_v : status_hold;
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            cs_d <= 1'b1;
            seen_tag <= 1'b0;
            cmd <= CMD_RESET;
            status_hold <= FAULT_RESET;
        end
        else
        begin
            cs_d <= cs_s;
            seen_tag <= next_seen;
            cmd <= next_cmd;
            status_hold <= next_hold;
        end
    end

    // ****************************************
    // output channels
    // ****************************************
    always_comb
    begin
        eff_on = cmd[ON_LSB +: N_OUT];
        // sleep must hold the direct drives off as well
        eff_on[DD5_BIT] = cmd[ON_LSB + DD5_BIT] | (dd5_s & en_s);
        eff_on[DD6_BIT] = cmd[ON_LSB + DD6_BIT] | (dd6_s & en_s);
    end

    genvar gi;
    generate
        for (gi = 0; gi < N_OUT; gi++)
        begin : g_chan
            ossc_chan u_chan
            (
                .on_cmd(eff_on[gi]),
                .det_en(cmd[OLD_LSB + gi]),
                .thermal(th_s[gi]),
                .overcurrent(oc_s[gi]),
                .open_load(ol_s[gi]),
                .overvolt(ov_s),
                .drive(drive_v[gi]),
                .fault(fault_v[gi])
            );
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            output_drive <= FAULT_RESET;
            open_load_current_en <= FAULT_RESET;
        end
        else
        begin
            output_drive <= drive_v;
            open_load_current_en <= cmd[OLD_LSB +: N_OUT];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_apply_only_on_rise;
        @(posedge mclk) disable iff (!resetn)
        (en_s && $past(en_s) && cmd != $past(cmd)) |-> $past(cs_rise);
    endproperty
    a_apply_only_on_rise: assert property (p_apply_only_on_rise)
        else $error("command changed without chip select rise");

    property p_bad_count_ignored;
        @(posedge mclk) disable iff (!resetn)
        (cs_rise && en_s && !frame_ok) |=> (cmd == $past(cmd));
    endproperty
    a_bad_count_ignored: assert property (p_bad_count_ignored)
        else $error("frame with bad pulse count was applied");

    property p_good_frame_applied;
        @(posedge mclk) disable iff (!resetn)
        (cs_rise && en_s && frame_ok) |=> (cmd == $past(sr));
    endproperty
    a_good_frame_applied: assert property (p_good_frame_applied)
        else $error("valid frame not applied");

    property p_overvoltage_off;
        @(posedge mclk) disable iff (!resetn)
        ov_s [*2] |-> (output_drive == FAULT_RESET);
    endproperty
    a_overvoltage_off: assert property (p_overvoltage_off)
        else $error("output on during overvoltage");

    property p_thermal_local;
        @(posedge mclk) disable iff (!resetn)
        (th_s == 8'h04 && !ov_s && eff_on[3]) |=> (output_drive[3] && !output_drive[2]);
    endproperty
    a_thermal_local: assert property (p_thermal_local)
        else $error("thermal shutdown not local to one output");

    property p_sleep_clears;
        @(posedge mclk) disable iff (!resetn)
        !en_s [*3] |-> (cmd == CMD_RESET) && (output_drive == FAULT_RESET)
            && (open_load_current_en == FAULT_RESET);
    endproperty
    a_sleep_clears: assert property (p_sleep_clears)
        else $error("sleep did not clear outputs");

    property p_direct_drive;
        @(posedge mclk) disable iff (!resetn)
        (dd5_s && en_s && !th_s[DD5_BIT] && !ov_s) |=> output_drive[DD5_BIT];
    endproperty
    a_direct_drive: assert property (p_direct_drive)
        else $error("direct drive five ignored");

    property p_open_load_masked;
        @(posedge mclk) disable iff (!resetn)
        (cs_s && !th_s[0] && !oc_s[0] && (eff_on[0] || !cmd[OLD_LSB]))
            |=> !status_hold[0];
    endproperty
    a_open_load_masked: assert property (p_open_load_masked)
        else $error("masked open load reported");

    property p_status_leading_zeros;
        @(posedge sclk) disable iff (cs_n || !resetn)
        (started && cnt < CNT_ZEROS) |=> !do_q;
    endproperty
    a_status_leading_zeros: assert property (p_status_leading_zeros)
        else $error("status upper byte not zero");

    property p_fault_reported;
        @(posedge mclk) disable iff (!resetn)
        (cs_s && th_s != 8'h00) |=> ((status_hold & $past(th_s)) == $past(th_s));
    endproperty
    a_fault_reported: assert property (p_fault_reported)
        else $error("thermal fault missing from status");
endmodule // ossc_ctrl

// >>> sim/ossc_host.sv
// Purpose: host side of the serial link, frames of up to 32 bits
// Assumes: link period 64 ns, data taken by the device on falling edges
// Notes: sclk stands low between frames
`timescale 1ns/100ps
module ossc_host
(
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic serial_command_in,
    input wire logic serial_status_out
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_command_in = 1'b0;
    end

    // ****************************************
    // one frame, msb first both ways
    // ****************************************
    task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
        q = '0;
        #3.3;
        cs_n = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_command_in = d[i];
            #16;
            sclk = 1'b1;
            #32;
            q = {q[30:0], serial_status_out};
            sclk = 1'b0;
            #16;
        end
        #40;
        cs_n = 1'b1;
        // released line must not keep the last bit
        serial_command_in = ~serial_command_in;
        #100;
    endtask

    // clocks with chip select high
    task automatic stray_clocks(input int n);
        repeat (n)
        begin
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
    endtask
endmodule // ossc_host

// >>> sim/ossc_ctrl_tb.sv
// Purpose: self-checking bench for the serial switch control
// Assumes: host model drives the link, bench drives the pins
// Notes: expected faults computed from the pin levels set here
`timescale 1ns/100ps
module ossc_ctrl_tb;
    import ossc_pkg::*;
    logic mclk, resetn, enable, dd5, dd6, ovp;
    logic sclk, cs_n, sdi, sdo, sdo_oe;
    logic [7:0] th, oc, ol, drive, olc_en;
    logic [31:0] rx;
    int failures;
    int comparisons;
    int odd_len[4] = '{15, 17, 20, 8};

    ossc_host host (.sclk(sclk), .cs_n(cs_n), .serial_command_in(sdi),
        .serial_status_out(sdo));

    ossc_ctrl uut (.mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
        .serial_command_in(sdi), .serial_status_out(sdo), .serial_status_oe(sdo_oe),
        .enable(enable), .direct_drive_five(dd5), .direct_drive_six(dd6),
        .battery_supply_overvoltage(ovp), .thermal_limit_fault(th),
        .overcurrent_fault(oc), .open_load_sense(ol), .output_drive(drive),
        .open_load_current_en(olc_en));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic logic [7:0] exp_fault(input logic [7:0] on_b, input logic [7:0] en_b);
        return th | oc | (ol & ~on_b & en_b);
    endfunction

    task automatic frame(input int n, input logic [31:0] d, input logic [31:0] expq);
        fork
            host.xfer(n, d, rx);
            begin
                #200;
                check(sdo_oe, 1'b1, "driven out");
            end
        join
        wait_clk(6);
        check(rx, expq, "status word");
    endtask

    task automatic pins(input logic [7:0] t, input logic [7:0] o, input logic [7:0] l);
        @(posedge mclk);
        th <= t;
        oc <= o;
        ol <= l;
        wait_clk(6);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #300000;
        failures++;
        print_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        failures = 0;
        comparisons = 0;
        {dd5, dd6, ovp} = 3'h0;
        // reset falls after time zero so the link flops see its edge
        resetn = 1'b1;
        enable = 1'b1;
        {th, oc, ol} = '0;
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        wait_clk(5);
        check(drive, 8'h00, "reset drive");
        check(olc_en, 8'h00, "reset detect");
        check(sdo_oe, 1'b0, "idle enable");
        $display("test reset done");
        frame(16, 32'h0000_A53C, 32'h0000_0000);
        check(drive, 8'h3C, "applied drive");
        check(olc_en, 8'hA5, "applied detect");
        check(sdo_oe, 1'b0, "released out");
        pins(8'h04, 8'h01, 8'hFF);
        check(drive, 8'h38, "thermal off");
        frame(16, 32'h0000_FF00, {24'h0, exp_fault(8'h3C, 8'hA5)});
        frame(16, 32'h0000_0000, {24'h0, exp_fault(8'h00, 8'hFF)});
        frame(16, 32'h0000_A53C, {24'h0, exp_fault(8'h00, 8'h00)});
        pins(8'h00, 8'h00, 8'h00);
        check(drive, 8'h3C, "thermal restore");
        $display("test faults done");
        @(posedge mclk);
        ovp <= 1'b1;
        wait_clk(6);
        check(drive, 8'h00, "overvoltage off");
        @(posedge mclk);
        ovp <= 1'b0;
        wait_clk(6);
        check(drive, 8'h3C, "overvoltage restore");
        $display("test overvoltage done");
        frame(16, 32'h0000_FF00, 32'h0000_0000);
        @(posedge mclk);
        {dd5, dd6} <= 2'b11;
        pins(8'h00, 8'h00, 8'hFF);
        check(drive, 8'h30, "direct drives");
        frame(16, 32'h0000_0000, {24'h0, exp_fault(8'h30, 8'hFF)});
        @(posedge mclk);
        {dd5, dd6} <= 2'b00;
        pins(8'h00, 8'h00, 8'h00);
        $display("test direct drive done");
        frame(16, 32'h0000_A53C, 32'h0000_0000);
        foreach (odd_len[i])
        begin
            host.xfer(odd_len[i], 32'hFFFF_FFFF, rx);
            wait_clk(6);
            check(drive, 8'h3C, "odd count ignored");
        end
        frame(24, 32'h005A_0F81, 32'h0000_005A);
        check(drive, 8'h81, "chain drive");
        check(olc_en, 8'h0F, "chain detect");
        frame(32, 32'hC3C3_0042, 32'h0000_C3C3);
        check(drive, 8'h42, "long drive");
        host.stray_clocks(16);
        wait_clk(6);
        check(drive, 8'h42, "stray clocks");
        $display("test pulse count done");
        frame(16, 32'h0000_FF00, 32'h0000_0000);
        @(posedge mclk);
        enable <= 1'b0;
        dd5 <= 1'b1;
        wait_clk(6);
        check(olc_en, 8'h00, "sleep detect");
        check(drive, 8'h00, "sleep drive");
        @(posedge mclk);
        enable <= 1'b1;
        dd5 <= 1'b0;
        wait_clk(6);
        check(drive, 8'h00, "wake drive");
        check(olc_en, 8'h00, "wake detect");
        $display("test sleep done");
        print_verdict();
    end
endmodule // ossc_ctrl_tb
